// *** design/qrs_ctrl.sv ***
// Memory controller end of the burst SRAM link, with its read-return FIFO
// Function
// - Write select low on true edge starts write; a read select on the same edge wins
// - Byte selects sampled on every beat edge
// - Deselected byte lane keeps its stored value
// - Select n governs nine-bit lane n
// - Byte selects qualify the same beat's data
// - Shared address sampled on true edge only
// - Address ignored unless a port is selected
// - Four arrays, address width per variant
// - Read data driven on every beat edge
// - Outputs released when read port idles
// - Read select starts four-beat burst, completes
// - Write data sampled on each beat edge
`timescale 1ns/10ps
module qrs_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic empty_o
);
	localparam int PW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << PW) != DEPTH)
			$error("qrs_fifo: depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0] cnt_r;

	// Handshake decode
	wire full = (cnt_r == (PW+1)'(DEPTH));
	wire empty = (cnt_r == '0);
	wire push = in_valid_i & ~full;
	wire pop = out_ready_i & ~empty;

	// Storage write
	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
			mem_r[wp_r] <= in_data_i;
	end

	// Pointers and fill count
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else if (ce_i)
		begin
			wp_r <= push ? wp_r + 1'b1 : wp_r;
			rp_r <= pop ? rp_r + 1'b1 : rp_r;
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem_r[rp_r];
	assign empty_o = empty;
endmodule

module qrs_ctrl
	import qrs_pkg::*;
#(
	parameter int DW = QRS_DATA_W,
	parameter int AW = QRS_ADDR_W,
	parameter int FIFO_DEPTH = QRS_FIFO_DEPTH
)(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	qrs_if.ctl PORT,
	input wire logic CMD_VALID_I,
	input wire logic CMD_WRITE_I,
	input wire logic [AW-1:0] CMD_ADDR_I,
	input wire logic [4*DW-1:0] WR_DATA_I,
	input wire logic [4*(DW/9)-1:0] WR_BWS_N_I,
	output logic CMD_READY_O,
	output logic RD_VALID_O,
	input wire logic RD_READY_I,
	output logic [DW-1:0] RD_DATA_O
);
	localparam int NB = DW / QRS_LANE_W;

	initial
	begin
		if (FIFO_DEPTH < 4)
			$error("qrs_ctrl: return FIFO must hold a whole burst");
	end

	qrs_state_t st_r;
	qrs_state_t st_nxt;
	logic k_r;
	logic cmd_ready_r;
	logic wps_n_r;
	logic rps_n_r;
	logic [AW-1:0] addr_r;
	logic [4*DW-1:0] wd_r;
	logic [4*NB-1:0] wb_r;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic fifo_in_ready;
	logic fifo_empty;

	// Command take; only offered one cycle before a true edge
	wire accept = CMD_VALID_I & cmd_ready_r;
	wire take_wr = accept & CMD_WRITE_I;
	wire take_rd = accept & ~CMD_WRITE_I;
	wire push = PORT.q_oe & fifo_in_ready;
	wire wr_last = (st_r == QRS_WRITE) && (cnt_r == 3'h3);
	wire rd_last = (st_r == QRS_READ) && push && (cnt_r == 3'h3);

	// Next state and beat count
	assign st_nxt = take_wr ? QRS_WRITE : (take_rd ? QRS_READ : ((wr_last || rd_last) ? QRS_IDLE : st_r));
	assign cnt_nxt = accept ? QRS_CNT_RST : ((st_r == QRS_WRITE || push) ? cnt_r + 3'h1 : cnt_r);

	// Ready only with an empty FIFO, so a whole burst always fits
	wire ready_nxt = (st_nxt == QRS_IDLE) & k_r & fifo_empty;

	// Clock phase and sequencing
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_r <= QRS_IDLE;
			k_r <= QRS_PHASE_RST;
			cmd_ready_r <= 1'b0;
			cnt_r <= QRS_CNT_RST;
		end
		else if (CE_I)
		begin
			st_r <= st_nxt;
			k_r <= ~k_r;
			cmd_ready_r <= ready_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Pin drive; beat 0 goes out with the select, one beat per edge after
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wps_n_r <= QRS_SEL_N_RST;
			rps_n_r <= QRS_SEL_N_RST;
			addr_r <= '0;
			wd_r <= '0;
			wb_r <= '1;
		end
		else if (CE_I)
		begin
			wps_n_r <= ~take_wr;
			rps_n_r <= ~take_rd;
			addr_r <= accept ? CMD_ADDR_I : addr_r;
			wd_r <= take_wr ? WR_DATA_I : {{DW{1'b0}}, wd_r[4*DW-1:DW]};
			wb_r <= take_wr ? WR_BWS_N_I : {{NB{1'b1}}, wb_r[4*NB-1:NB]};
		end
	end

	qrs_fifo #(
		.WIDTH(DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.in_valid_i(PORT.q_oe),
		.in_ready_o(fifo_in_ready),
		.in_data_i(PORT.q),
		.out_valid_o(RD_VALID_O),
		.out_ready_i(RD_READY_I),
		.out_data_o(RD_DATA_O),
		.empty_o(fifo_empty)
	);

	assign PORT.k = k_r;
	assign PORT.write_port_select_n = wps_n_r;
	assign PORT.read_port_select_n = rps_n_r;
	assign PORT.addr = addr_r;
	assign PORT.d = wd_r[DW-1:0];
	assign PORT.byte_write_select_n = wb_r[NB-1:0];
	assign CMD_READY_O = cmd_ready_r;
endmodule

// *** design/qrs_device.sv ***
// Burst SRAM port: write and read bursts of four beats into lane-split storage
`timescale 1ns/10ps
module qrs_device
	import qrs_pkg::*;
#(
	parameter int DW = QRS_DATA_W,
	parameter int AW = QRS_ADDR_W,
	parameter int MEM_AW = QRS_MEM_AW
)(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	qrs_if.dev PORT,
	output logic RD_BUSY_O,
	output logic WR_BUSY_O
);
	localparam int NB = DW / QRS_LANE_W;
	localparam int IW = MEM_AW + QRS_BEAT_W;
	localparam int DEPTH = 1 << IW;

	// Refuse widths the lane and address logic cannot serve
	initial
	begin
		if (DW % QRS_LANE_W != 0 || (NB != 2 && NB != 4))
			$error("qrs_device: data width must be 18 or 36");
		if (MEM_AW < 1 || MEM_AW > AW)
			$error("qrs_device: stored address width out of range");
	end

	// Beat number picks one of the four arrays, address picks the row
	function automatic logic [IW-1:0] mem_index(input logic [MEM_AW-1:0] row, input logic [QRS_BEAT_W-1:0] beat);
		mem_index = {row, beat};
	endfunction

	logic [2:0] rd_left_r;
	logic [2:0] rd_left_nxt;
	logic [QRS_BEAT_W-1:0] rd_beat_r;
	logic [QRS_BEAT_W-1:0] rd_beat_nxt;
	logic [MEM_AW-1:0] rd_addr_r;
	logic [MEM_AW-1:0] rd_addr_nxt;
	logic [2:0] wr_left_r;
	logic [2:0] wr_left_nxt;
	logic [MEM_AW-1:0] wr_addr_r;
	logic [DW-1:0] q_r;
	logic [DW-1:0] q_nxt;
	logic oe_r;
	logic rd_busy_r;
	logic wr_busy_r;
	logic [DW-1:0] rd_word;

	// Request decode on the true clock edge
	wire is_true = PORT.k;
	wire rd_free = (rd_left_r <= 3'h1);
	wire rd_sel = is_true & ~PORT.read_port_select_n & rd_free;
	wire wr_sel = is_true & ~PORT.write_port_select_n & (wr_left_r == QRS_CNT_RST) & ~rd_sel;
	wire rd_drive = (rd_left_r != QRS_CNT_RST);

	// Write beat selection: the select edge is beat 0, then three more edges
	wire wr_busy = (wr_left_r != QRS_CNT_RST);
	wire wr_act = wr_sel | wr_busy;
	wire [2:0] wr_beat_full = QRS_BURST_LEN - wr_left_r;
	wire [QRS_BEAT_W-1:0] wr_beat = wr_sel ? QRS_BEAT_RST : wr_beat_full[QRS_BEAT_W-1:0];
	wire [MEM_AW-1:0] wr_addr = wr_sel ? PORT.addr[MEM_AW-1:0] : wr_addr_r;
	wire [IW-1:0] wr_idx = mem_index(wr_addr, wr_beat);
	wire [IW-1:0] rd_idx = mem_index(rd_addr_r, rd_beat_r);

	// Write counter: three beats remain after the one taken with the select
	assign wr_left_nxt = wr_sel ? 3'h3 : (wr_busy ? wr_left_r - 3'h1 : QRS_CNT_RST);

	// Read sequencing; a new burst may follow the last beat directly
	assign rd_left_nxt = rd_sel ? QRS_BURST_LEN : (rd_drive ? rd_left_r - 3'h1 : QRS_CNT_RST);
	assign rd_beat_nxt = rd_sel ? QRS_BEAT_RST : (rd_drive ? rd_beat_r + 2'h1 : rd_beat_r);
	assign rd_addr_nxt = rd_sel ? PORT.addr[MEM_AW-1:0] : rd_addr_r;

	// Output data: stored word while bursting, zero when released
	assign q_nxt = rd_drive ? rd_word : '0;

	// Storage, one array of flops per nine-bit lane
	genvar gl;
	generate
		for (gl = 0; gl < NB; gl++)
		begin : g_lane
			logic [QRS_LANE_W-1:0] lane_mem [0:DEPTH-1];
			wire lane_we = CE_I & wr_act & ~PORT.byte_write_select_n[gl];
			// Lane write; a deselected lane keeps its contents
			always_ff @(posedge MCLK_I)
			begin
				if (lane_we)
					lane_mem[wr_idx] <= PORT.d[gl*QRS_LANE_W +: QRS_LANE_W];
			end
			assign rd_word[gl*QRS_LANE_W +: QRS_LANE_W] = lane_mem[rd_idx];
		end
	endgenerate

	// Write burst state
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wr_left_r <= QRS_CNT_RST;
			wr_addr_r <= '0;
		end
		else if (CE_I)
		begin
			wr_left_r <= wr_left_nxt;
			wr_addr_r <= wr_addr;
		end
	end

	// Read burst state
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rd_left_r <= QRS_CNT_RST;
			rd_beat_r <= QRS_BEAT_RST;
			rd_addr_r <= '0;
		end
		else if (CE_I)
		begin
			rd_left_r <= rd_left_nxt;
			rd_beat_r <= rd_beat_nxt;
			rd_addr_r <= rd_addr_nxt;
		end
	end

	// Output drivers and status flags
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			q_r <= '0;
			oe_r <= 1'b0;
			rd_busy_r <= 1'b0;
			wr_busy_r <= 1'b0;
		end
		else if (CE_I)
		begin
			q_r <= q_nxt;
			oe_r <= rd_drive;
			rd_busy_r <= (rd_left_nxt != QRS_CNT_RST);
			wr_busy_r <= (wr_left_nxt != QRS_CNT_RST);
		end
	end

	assign PORT.q = q_r;
	assign PORT.q_oe = oe_r;
	assign RD_BUSY_O = rd_busy_r;
	assign WR_BUSY_O = wr_busy_r;
endmodule

// *** include/qrs_if.sv ***
// Pin-level link between the memory controller and the burst SRAM port
`timescale 1ns/10ps
interface qrs_if #(
	parameter int DW = 18,
	parameter int AW = 20
);
	localparam int NB = DW / 9;
	logic k;
	logic write_port_select_n;
	logic read_port_select_n;
	logic [AW-1:0] addr;
	logic [NB-1:0] byte_write_select_n;
	logic [DW-1:0] d;
	logic [DW-1:0] q;
	logic q_oe;
	modport ctl (
		output k,
		output write_port_select_n,
		output read_port_select_n,
		output addr,
		output byte_write_select_n,
		output d,
		input q,
		input q_oe
	);
	modport dev (
		input k,
		input write_port_select_n,
		input read_port_select_n,
		input addr,
		input byte_write_select_n,
		input d,
		output q,
		output q_oe
	);
endinterface

// *** include/qrs_pkg.sv ***
// Shared constants for the burst SRAM port and its controller
package qrs_pkg;
	localparam int QRS_DATA_W = 18;
	localparam int QRS_ADDR_W = 20;
	localparam int QRS_LANE_W = 9;
	localparam int QRS_MEM_AW = 6;
	localparam int QRS_FIFO_DEPTH = 4;
	localparam int QRS_BEAT_W = 2;
	localparam logic [2:0] QRS_BURST_LEN = 3'h4;
	localparam logic [2:0] QRS_CNT_RST = 3'h0;
	localparam logic [1:0] QRS_BEAT_RST = 2'h0;
	localparam logic QRS_PHASE_RST = 1'b0;
	localparam logic QRS_SEL_N_RST = 1'b1;
	typedef enum logic [1:0] {
		QRS_IDLE = 2'b00,
		QRS_WRITE = 2'b01,
		QRS_READ = 2'b10
	} qrs_state_t;
endpackage

// *** verification/qrs_monitor.sv ***
// Checker for the controller-to-SRAM pin link
`timescale 1ns/10ps
module qrs_monitor #(
	parameter int DW = 18
)(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic k,
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire logic [DW/9-1:0] byte_write_select_n,
	input wire logic [DW-1:0] q,
	input wire logic q_oe
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// Selects only on true-clock beats, beats alternate
	a_wsel_true_edge: assert property (!write_port_select_n |-> k)
		else $error("write select off true edge");
	a_rsel_true_edge: assert property (!read_port_select_n |-> k)
		else $error("read select off true edge");
	a_beat_phase_alt: assert property (!$past(RST_I) |-> k != $past(k))
		else $error("beat phase did not alternate");
	// Burst spacing on the selects
	a_write_burst_gap: assert property (!write_port_select_n |=> write_port_select_n [*3])
		else $error("write select inside burst");
	a_read_burst_gap: assert property (!read_port_select_n |=> read_port_select_n [*3])
		else $error("read select inside burst");
	// Read data window of four beats
	a_read_four_beats: assert property (!read_port_select_n |-> ##2 q_oe [*4])
		else $error("read beats missing");
	a_oe_from_read: assert property ($rose(q_oe) |-> $past(read_port_select_n, 2) == 1'b0)
		else $error("output enable without read");
	a_oe_release: assert property (!read_port_select_n ##1 read_port_select_n [*4] |-> ##2 !q_oe)
		else $error("outputs not released");
	a_q_parked: assert property (!q_oe |-> q == '0)
		else $error("read data while released");
	// Main scenarios
	c_partial_write: cover property (!write_port_select_n ##1 (byte_write_select_n != '0 && byte_write_select_n != '1));
	c_read_data: cover property (!read_port_select_n ##2 q_oe);
	c_release: cover property ($fell(q_oe));
endmodule

// *** verification/quad_rate_sram_port_interface_bench.sv ***
// Bench joining controller and SRAM port, with scoreboard
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module quad_rate_sram_port_interface_bench;
	import qrs_pkg::*;
	logic MCLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic v = 1'b0;
	logic wr = 1'b0;
	logic rdy = 1'b0;
	logic [19:0] ad = 20'h0;
	logic [71:0] wd = 72'h0;
	logic [7:0] bw = 8'hFF;
	logic cr;
	logic rv;
	logic [17:0] rd;
	logic [17:0] e;
	logic rd_busy;
	logic wr_busy;
	int rb_left = 0;
	int wb_left = 0;
	logic [15:0] lf = 16'hF6BD;
	logic [15:0] rs = 16'hF6BD;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [17:0] exp_q[$];
	logic [17:0] mem[4][64];
	qrs_if lnk();
	qrs_device qrs_device_i(.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(1'b1), .PORT(lnk.dev),
		.RD_BUSY_O(rd_busy), .WR_BUSY_O(wr_busy));
	qrs_ctrl qrs_ctrl_i(.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(1'b1), .PORT(lnk.ctl), .CMD_VALID_I(v),
		.CMD_WRITE_I(wr), .CMD_ADDR_I(ad), .WR_DATA_I(wd), .WR_BWS_N_I(bw), .CMD_READY_O(cr),
		.RD_VALID_O(rv), .RD_READY_I(rdy), .RD_DATA_O(rd));
	qrs_monitor qrs_monitor_i(.MCLK_I(MCLK_I), .RST_I(RST_I), .k(lnk.k),
		.write_port_select_n(lnk.write_port_select_n), .read_port_select_n(lnk.read_port_select_n),
		.byte_write_select_n(lnk.byte_write_select_n), .q(lnk.q), .q_oe(lnk.q_oe));
	always #2 MCLK_I = ~MCLK_I;
	// Step of the pseudo-random source
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Issue one burst and note what it should leave or return
	task automatic cmd(input logic w, input logic full, input logic [5:0] a);
		for (int i = 0; i < 4; i++)
		begin
			lf = nx(lf);
			wd = {wd[53:0], lf, lf[15:14]};
		end
		@(posedge MCLK_I);
		#1;
		v = 1'b1;
		wr = w;
		bw = full ? 8'h00 : lf[7:0];
		ad = {lf[13:0], a};
		for (int b = 0; b < 4; b++)
			for (int l = 0; l < 2; l++)
				if (w && !bw[2*b+l]) mem[b][a][9*l+:9] = wd[18*b+9*l+:9];
				else if (!w && l == 0) exp_q.push_back(mem[b][a]);
		while (cr !== 1'b1)
		begin
			@(posedge MCLK_I);
			#1;
		end
		@(posedge MCLK_I);
		#1;
		v = 1'b0;
	endtask
	task conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Random stalls on the read-return side
	always @(posedge MCLK_I)
	begin
		rs <= nx(rs);
		rdy <= #1 rs[0] | rs[1];
	end
	// Scoreboard on popped words, the parked pins and the busy flags
	always @(posedge MCLK_I)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			conclude;
		end
		else
		begin
			if (lnk.q_oe === 1'b0) `CHK(lnk.q, 18'h0)
			if (rv === 1'b1 && rdy === 1'b1)
			begin
				e = exp_q.size() ? exp_q.pop_front() : 18'h0;
				`CHK(rd, e)
			end
			// Busy flags follow the selects seen on the pins
			if (RST_I === 1'b0)
			begin
				`CHK(rd_busy, rb_left != 0)
				`CHK(wr_busy, wb_left != 0)
			end
			if (lnk.k === 1'b1 && lnk.read_port_select_n === 1'b0 && rb_left <= 1)
				rb_left = 4;
			else if (rb_left != 0)
				rb_left--;
			if (lnk.k === 1'b1 && lnk.write_port_select_n === 1'b0 && wb_left == 0)
				wb_left = 3;
			else if (wb_left != 0)
				wb_left--;
		end
	end
	// Fill edge rows, then partial writes each read back at once
	initial
	begin
		repeat (12) @(posedge MCLK_I);
		#1;
		RST_I = 1'b0;
		for (int i = 0; i < 8; i++) cmd(1'b1, 1'b1, 6'(i < 4 ? i : 56 + i));
		for (int i = 0; i < 8; i++)
		begin
			cmd(1'b1, 1'b0, 6'(i < 4 ? i : 56 + i));
			cmd(1'b0, 1'b0, 6'(i < 4 ? i : 56 + i));
		end
		while (exp_q.size() != 0) @(posedge MCLK_I);
		repeat (8) @(posedge MCLK_I);
		conclude;
	end
endmodule
